/* vmac_pkg.sv */
// Purpose: Shared constants and types for the two-lane word multiply unit
// Assumes: 32-bit AXI4-Lite register bus, 64-bit operands
// Notes:   Lane high is bits 63:32, lane low is bits 31:0
`default_nettype none

package vmac_pkg;

  // Register offsets, byte addresses
  localparam logic [31:0] VECTOR_STATUS_CONTROL_REG_OFFSET = 32'h0000_0000;
  localparam logic [31:0] ACC_HIGH_OFFSET                  = 32'h0000_0004;
  localparam logic [31:0] ACC_LOW_OFFSET                   = 32'h0000_0008;

  // Status field positions
  localparam int LOW_OV_BIT      = 0;
  localparam int HIGH_OV_BIT     = 1;
  localparam int LOW_STICKY_BIT  = 2;
  localparam int HIGH_STICKY_BIT = 3;

  // Values after reset
  localparam logic [63:0] ACC_RESET    = 64'h0000_0000_0000_0000;
  localparam logic [3:0]  STATUS_RESET = 4'h0;

  // Clamp values
  localparam logic [31:0] SSAT_MIN = 32'h8000_0000;
  localparam logic [31:0] SSAT_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] USAT_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] USAT_MIN = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Issued operations
  typedef enum logic [2:0] {
    OP_SIGNED_SAT_ACC_NEG,
    OP_UNSIGNED_MUL,
    OP_UNSIGNED_ACC,
    OP_UNSIGNED_ACC_NEG,
    OP_USAT_ACC,
    OP_USAT_ACC_NEG,
    OP_FRAC_MUL,
    OP_SIGNED_FRACTION_WORD_MAC
  } op_e;

  // Per-lane arithmetic modes
  typedef enum logic [2:0] {
    LANE_PRODUCT,
    LANE_ADD_WRAP,
    LANE_SUB_WRAP,
    LANE_USAT_ADD,
    LANE_USAT_SUB,
    LANE_SSAT_SUB
  } lane_mode_e;

endpackage

`default_nettype wire

/* vmac_word_lane.sv */
// Purpose: One 32-bit lane: multiply, then add or subtract the acc word
// Assumes: Purely combinational, registered by the parent
// Notes:   Low product bits do not depend on operand signedness
`default_nettype none

module vmac_word_lane
  import vmac_pkg::*;
(
  input  wire logic [31:0] lane_a,      // First source word
  input  wire logic [31:0] lane_b,      // Second source word
  input  wire logic [31:0] acc_word,    // Matching accumulator word
  input  wire lane_mode_e  lane_mode,   // Arithmetic mode
  output logic      [31:0] lane_result, // Lane result
  output logic             lane_ov      // Lane overflow or underflow
);

  logic [63:0] full_product;
  logic [31:0] low_product;
  logic [32:0] wide;

  // Unsigned product; low half is shared by signed use
  assign full_product = lane_a * lane_b;
  assign low_product  = full_product[31:0];

  // Accumulate and clamp
  always_comb
  begin
    wide        = 33'h0_0000_0000;
    lane_result = low_product;
    lane_ov     = 1'b0;
    case (lane_mode)
      LANE_PRODUCT: lane_result = low_product;
      LANE_ADD_WRAP: lane_result = acc_word + low_product;
      LANE_SUB_WRAP: lane_result = acc_word - low_product;
      LANE_USAT_ADD:
      begin
        wide        = {1'b0, acc_word} + {1'b0, low_product};
        lane_ov     = wide[32];
        lane_result = lane_ov ? USAT_MAX : wide[31:0];
      end
      LANE_USAT_SUB:
      begin
        wide        = {1'b0, acc_word} - {1'b0, low_product};
        lane_ov     = wide[32];
        lane_result = lane_ov ? USAT_MIN : wide[31:0];
      end
      LANE_SSAT_SUB:
      begin
        wide    = {acc_word[31], acc_word} - {low_product[31], low_product};
        lane_ov = wide[32] ^ wide[31];
        if (lane_ov)
          lane_result = wide[32] ? SSAT_MIN : SSAT_MAX;
        else
          lane_result = wide[31:0];
      end
      default: lane_result = low_product;
    endcase
  end

endmodule

`default_nettype wire

/* vmac_frac_mult.sv */
// Purpose: Signed fractional multiply of two low words to 64 bits
// Assumes: Combinational, modulo result
// Notes:   Doubling drops the redundant sign bit
`default_nettype none

module vmac_frac_mult
(
  input  wire logic [31:0] frac_a,      // First low word
  input  wire logic [31:0] frac_b,      // Second low word
  output logic      [63:0] frac_product // Fractional product
);

  logic signed [63:0] full_product;

  // Signed product, shifted left one place
  assign full_product = $signed(frac_a) * $signed(frac_b);
  assign frac_product = {full_product[62:0], 1'b0};

endmodule

`default_nettype wire

/* vector_word_multiply_accumulate.sv */
// Purpose: Two-lane word multiply and multiply-accumulate datapath
// Assumes: Decode stage supplies op, operands and acc-write bit
// Notes:   One cycle from issue to result; AXI4-Lite for acc and status
// Notes on behaviour
// - Signed saturating acc-negative: acc word minus low product per lane
// - Signed lane overflow clamps to most negative or most positive
// - Saturating ops load overflow bits and OR them into sticky bits
// - Unsigned modulo multiply puts low products in result, no status
// - Low product bits are the same for signed and unsigned operands
// - Plain multiplies copy result into accumulator only if bit set
// - Unsigned modulo acc: acc word plus low product, wrapping
// - Unsigned modulo acc-negative: acc word minus low product, wrapping
// - Unsigned saturating acc clamps to all ones on carry out
// - Unsigned add overflow sets lane overflow and sticky bits
// - Unsigned saturating acc-negative clamps to zero on borrow
// - Unsigned subtract underflow sets lane overflow and sticky bits
// - Fractional multiply of low words gives 64-bit result, no status
// - Fractional mac adds product to full accumulator, wrapping
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none

module vector_word_multiply_accumulate
  import vmac_pkg::*;
#(
  parameter int ADDR_W = 8 // AXI address width
)
(
  input  wire logic              clk,                        // Clock
  input  wire logic              resetn,                     // Async reset
  input  wire logic              issue_valid,                // Op issued
  output logic                   issue_ready,                // Op accepted
  input  wire op_e               issue_op,                   // Operation
  input  wire logic              issue_acc_write,            // Acc-write bit
  input  wire logic [63:0]       first_source_register,      // First source
  input  wire logic [63:0]       second_source_register,     // Second source
  output logic                   result_valid,               // Result pulse
  output logic      [63:0]       result_data,                // Destination
  output logic      [63:0]       accumulator_reg,            // Accumulator
  output logic                   high_lane_overflow,         // High ov
  output logic                   low_lane_overflow,          // Low ov
  output logic                   high_lane_sticky_overflow,  // High sticky
  output logic                   low_lane_sticky_overflow,   // Low sticky
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,               // Write address
  input  wire logic              s_axi_awvalid,              // Addr valid
  output logic                   s_axi_awready,              // Addr ready
  input  wire logic [31:0]       s_axi_wdata,                // Write data
  input  wire logic [3:0]        s_axi_wstrb,                // Byte enables
  input  wire logic              s_axi_wvalid,               // Data valid
  output logic                   s_axi_wready,               // Data ready
  output logic      [1:0]        s_axi_bresp,                // Write resp
  output logic                   s_axi_bvalid,               // Resp valid
  input  wire logic              s_axi_bready,               // Resp ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,               // Read address
  input  wire logic              s_axi_arvalid,              // Addr valid
  output logic                   s_axi_arready,              // Addr ready
  output logic      [31:0]       s_axi_rdata,                // Read data
  output logic      [1:0]        s_axi_rresp,                // Read resp
  output logic                   s_axi_rvalid,               // Data valid
  input  wire logic              s_axi_rready                // Data ready
);

  // Datapath state
  logic        result_valid_ff;
  logic        nxt_result_valid;
  logic [63:0] result_data_ff;
  logic [63:0] nxt_result_data;
  logic [63:0] accumulator_reg_ff;
  logic [63:0] nxt_accumulator_reg;
  logic [3:0]  vector_status_control_reg_ff;
  logic [3:0]  nxt_vector_status_control_reg;

  // Bus state
  logic              aw_got_ff;
  logic              nxt_aw_got;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [ADDR_W-1:0] nxt_awaddr;
  logic              w_got_ff;
  logic              nxt_w_got;
  logic [31:0]       wdata_ff;
  logic [31:0]       nxt_wdata;
  logic [3:0]        wstrb_ff;
  logic [3:0]        nxt_wstrb;
  logic              bvalid_ff;
  logic              nxt_bvalid;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;

  // Decode and datapath wires
  logic        issue_fire;
  lane_mode_e  lane_mode;
  logic        sat_op;
  logic        acc_upd;
  logic        frac_op;
  logic        frac_acc;
  logic [31:0] hi_result;
  logic [31:0] lo_result;
  logic        hi_ov;
  logic        lo_ov;
  logic [63:0] frac_product;
  logic [63:0] dp_result;
  logic        bus_wr;
  logic        wr_status;
  logic        wr_acc_hi;
  logic        wr_acc_lo;
  logic        acc_bus_wr;
  logic [1:0]  sticky_clear;
  logic [31:0] wr_mask;

  assign issue_ready = 1'b1;
  assign issue_fire  = issue_valid;

  // Operation decode
  always_comb
  begin
    lane_mode = LANE_PRODUCT;
    sat_op    = 1'b0;
    acc_upd   = 1'b1;
    frac_op   = 1'b0;
    frac_acc  = 1'b0;
    case (issue_op)
      OP_SIGNED_SAT_ACC_NEG:
      begin
        lane_mode = LANE_SSAT_SUB;
        sat_op    = 1'b1;
      end
      OP_UNSIGNED_MUL:
      begin
        lane_mode = LANE_PRODUCT;
        acc_upd   = issue_acc_write;
      end
      OP_UNSIGNED_ACC:     lane_mode = LANE_ADD_WRAP;
      OP_UNSIGNED_ACC_NEG: lane_mode = LANE_SUB_WRAP;
      OP_USAT_ACC:
      begin
        lane_mode = LANE_USAT_ADD;
        sat_op    = 1'b1;
      end
      OP_USAT_ACC_NEG:
      begin
        lane_mode = LANE_USAT_SUB;
        sat_op    = 1'b1;
      end
      OP_FRAC_MUL:
      begin
        frac_op = 1'b1;
        acc_upd = issue_acc_write;
      end
      OP_SIGNED_FRACTION_WORD_MAC:
      begin
        frac_op  = 1'b1;
        frac_acc = 1'b1;
      end
      default: acc_upd = 1'b0;
    endcase
  end

  // High lane
  vmac_word_lane u_lane_hi (
    .lane_a      (first_source_register[63:32]),
    .lane_b      (second_source_register[63:32]),
    .acc_word    (accumulator_reg_ff[63:32]),
    .lane_mode   (lane_mode),
    .lane_result (hi_result),
    .lane_ov     (hi_ov)
  );

  // Low lane
  vmac_word_lane u_lane_lo (
    .lane_a      (first_source_register[31:0]),
    .lane_b      (second_source_register[31:0]),
    .acc_word    (accumulator_reg_ff[31:0]),
    .lane_mode   (lane_mode),
    .lane_result (lo_result),
    .lane_ov     (lo_ov)
  );

  // Low word fractional multiplier
  vmac_frac_mult u_frac (
    .frac_a       (first_source_register[31:0]),
    .frac_b       (second_source_register[31:0]),
    .frac_product (frac_product)
  );

  // Result select
  always_comb
  begin
    if (frac_acc)
      dp_result = accumulator_reg_ff + frac_product;
    else if (frac_op)
      dp_result = frac_product;
    else
      dp_result = {hi_result, lo_result};
  end

  // Bus write decode
  assign bus_wr    = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_status = bus_wr &&
                     (awaddr_ff == ADDR_W'(VECTOR_STATUS_CONTROL_REG_OFFSET));
  assign wr_acc_hi = bus_wr && (awaddr_ff == ADDR_W'(ACC_HIGH_OFFSET));
  assign wr_acc_lo = bus_wr && (awaddr_ff == ADDR_W'(ACC_LOW_OFFSET));
  assign acc_bus_wr = wr_acc_hi || wr_acc_lo;
  assign wr_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                    {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign sticky_clear = (wr_status && wstrb_ff[0]) ?
                        wdata_ff[HIGH_STICKY_BIT:LOW_STICKY_BIT] : 2'h0;

  // Datapath next state
  always_comb
  begin
    nxt_result_valid = issue_fire;
    nxt_result_data  = issue_fire ? dp_result : result_data_ff;
    nxt_accumulator_reg = accumulator_reg_ff;
    if (wr_acc_hi)
      nxt_accumulator_reg[63:32] = (accumulator_reg_ff[63:32] & ~wr_mask) |
                                   (wdata_ff & wr_mask);
    if (wr_acc_lo)
      nxt_accumulator_reg[31:0] = (accumulator_reg_ff[31:0] & ~wr_mask) |
                                  (wdata_ff & wr_mask);
    if (issue_fire && acc_upd)
      nxt_accumulator_reg = dp_result;
    nxt_vector_status_control_reg = vector_status_control_reg_ff;
    nxt_vector_status_control_reg[LOW_STICKY_BIT] =
      vector_status_control_reg_ff[LOW_STICKY_BIT] & ~sticky_clear[0];
    nxt_vector_status_control_reg[HIGH_STICKY_BIT] =
      vector_status_control_reg_ff[HIGH_STICKY_BIT] & ~sticky_clear[1];
    if (issue_fire && sat_op)
    begin
      // Set wins over a same-cycle clear
      nxt_vector_status_control_reg[HIGH_OV_BIT] = hi_ov;
      nxt_vector_status_control_reg[LOW_OV_BIT]  = lo_ov;
      if (hi_ov)
        nxt_vector_status_control_reg[HIGH_STICKY_BIT] = 1'b1;
      if (lo_ov)
        nxt_vector_status_control_reg[LOW_STICKY_BIT] = 1'b1;
    end
  end

  // Datapath registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      result_valid_ff              <= 1'b0;
      result_data_ff               <= ACC_RESET;
      accumulator_reg_ff           <= ACC_RESET;
      vector_status_control_reg_ff <= STATUS_RESET;
    end
    else
    begin
      result_valid_ff              <= nxt_result_valid;
      result_data_ff               <= nxt_result_data;
      accumulator_reg_ff           <= nxt_accumulator_reg;
      vector_status_control_reg_ff <= nxt_vector_status_control_reg;
    end
  end

  // AXI channel next state
  always_comb
  begin
    nxt_aw_got = aw_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_got  = w_got_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (bus_wr)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = (wr_status || acc_bus_wr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(VECTOR_STATUS_CONTROL_REG_OFFSET))
        nxt_rdata = {28'h000_0000, vector_status_control_reg_ff};
      else if (s_axi_araddr == ADDR_W'(ACC_HIGH_OFFSET))
        nxt_rdata = accumulator_reg_ff[63:32];
      else if (s_axi_araddr == ADDR_W'(ACC_LOW_OFFSET))
        nxt_rdata = accumulator_reg_ff[31:0];
      else
      begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = RESP_SLVERR;
      end
    end
    else if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
  end

  // AXI channel registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
      w_got_ff  <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      awaddr_ff <= nxt_awaddr;
      w_got_ff  <= nxt_w_got;
      wdata_ff  <= nxt_wdata;
      wstrb_ff  <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  // Outputs
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign result_valid  = result_valid_ff;
  assign result_data   = result_data_ff;
  assign accumulator_reg = accumulator_reg_ff;
  assign high_lane_overflow = vector_status_control_reg_ff[HIGH_OV_BIT];
  assign low_lane_overflow  = vector_status_control_reg_ff[LOW_OV_BIT];
  assign high_lane_sticky_overflow =
    vector_status_control_reg_ff[HIGH_STICKY_BIT];
  assign low_lane_sticky_overflow =
    vector_status_control_reg_ff[LOW_STICKY_BIT];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_ssat_clamp;
    issue_fire && issue_op == OP_SIGNED_SAT_ACC_NEG && lo_ov |=>
      result_data_ff[31:0] == SSAT_MIN || result_data_ff[31:0] == SSAT_MAX;
  endproperty
  a_ssat_clamp: assert property (p_ssat_clamp)
    else $error("signed clamp value wrong");

  property p_ov_load;
    issue_fire && sat_op |=> high_lane_overflow == $past(hi_ov) &&
      low_lane_overflow == $past(lo_ov);
  endproperty
  a_ov_load: assert property (p_ov_load)
    else $error("overflow bits not loaded");

  property p_sticky_hold;
    $fell(low_lane_sticky_overflow) |-> $past(sticky_clear[0]);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky bit dropped without clear");

  property p_umul_low;
    issue_fire && issue_op == OP_UNSIGNED_MUL |=>
      result_data_ff[31:0] == 32'($past(first_source_register[31:0]) *
                                  $past(second_source_register[31:0])) &&
      $stable(vector_status_control_reg_ff);
  endproperty
  a_umul_low: assert property (p_umul_low)
    else $error("unsigned low product wrong");

  property p_acc_copy;
    issue_fire && (issue_op == OP_UNSIGNED_MUL || issue_op == OP_FRAC_MUL)
      && issue_acc_write |=> accumulator_reg_ff == result_data_ff;
  endproperty
  a_acc_copy: assert property (p_acc_copy)
    else $error("accumulator copy missing");

  property p_acc_hold;
    !(issue_fire && acc_upd) && !acc_bus_wr |=> $stable(accumulator_reg_ff);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulator changed unexpectedly");

  property p_uacc_wrap;
    issue_fire && issue_op == OP_UNSIGNED_ACC |=>
      result_data_ff[31:0] == 32'($past(accumulator_reg_ff[31:0]) +
        32'($past(first_source_register[31:0]) *
            $past(second_source_register[31:0])));
  endproperty
  a_uacc_wrap: assert property (p_uacc_wrap)
    else $error("unsigned accumulate sum wrong");

  property p_usat_add;
    issue_fire && issue_op == OP_USAT_ACC && hi_ov |=>
      result_data_ff[63:32] == USAT_MAX && high_lane_sticky_overflow;
  endproperty
  a_usat_add: assert property (p_usat_add)
    else $error("unsigned add clamp wrong");

  property p_usat_sub;
    issue_fire && issue_op == OP_USAT_ACC_NEG && lo_ov |=>
      result_data_ff[31:0] == USAT_MIN && low_lane_sticky_overflow;
  endproperty
  a_usat_sub: assert property (p_usat_sub)
    else $error("unsigned subtract clamp wrong");

  property p_frac_mac;
    issue_fire && issue_op == OP_SIGNED_FRACTION_WORD_MAC |=>
      result_data_ff == $past(accumulator_reg_ff) + $past(frac_product) &&
      accumulator_reg_ff == result_data_ff;
  endproperty
  a_frac_mac: assert property (p_frac_mac)
    else $error("fractional mac wrong");

endmodule

`default_nettype wire

/* vmac_issuer.sv */
// Purpose: Decode stage and register file model that issues one op
// Assumes: Bench calls issue just after a rising clock edge
// Notes:   Released sources are inverted so stale values never match
`default_nettype none

module vmac_issuer
  import vmac_pkg::*;
(
  input  wire logic        clk,                          // Clock
  input  wire logic        issue_ready,                  // Op accepted
  output var  logic        issue_valid = 1'b0,           // Op presented
  output var  op_e         issue_op = OP_UNSIGNED_MUL,   // Operation
  output var  logic        issue_acc_write = 1'b0,       // Acc-write bit
  output var  logic [63:0] first_source_register = '0,   // First source
  output var  logic [63:0] second_source_register = '0   // Second source
);
  timeunit 1ns;
  timeprecision 100ps;

  // Present one op, hold it until taken, then scramble the sources
  task automatic issue(input op_e op, input logic w, input logic [63:0] a, b);
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_acc_write <= w;
    first_source_register <= a;
    second_source_register <= b;
    do
      @(posedge clk);
    while (!issue_ready);
    issue_valid <= 1'b0;
    first_source_register <= ~a;
    second_source_register <= ~b;
  endtask
endmodule

`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the two-lane word multiply unit
// Assumes: Issue model drives ops, bench drives the register bus
// Notes:   Expected values come from the small reference in predict
`default_nettype none

module tb
  import vmac_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, resetn, result_valid, issue_valid, issue_ready;
  logic        issue_acc_write;
  op_e         issue_op;
  logic [63:0] first_source_register, second_source_register;
  logic [63:0] result_data, accumulator_reg, e_res, e_acm;
  logic        high_lane_overflow, low_lane_overflow;
  logic        high_lane_sticky_overflow, low_lane_sticky_overflow;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, e_st;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_errors = 0;
  int          n_checks = 0;

  // Device and issue model
  vector_word_multiply_accumulate vector_word_multiply_accumulate_i (
    .clk, .resetn, .issue_valid, .issue_ready, .issue_op, .issue_acc_write,
    .first_source_register, .second_source_register, .result_valid,
    .result_data, .accumulator_reg, .high_lane_overflow, .low_lane_overflow,
    .high_lane_sticky_overflow, .low_lane_sticky_overflow, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  vmac_issuer vmac_issuer_i (
    .clk, .issue_ready, .issue_valid, .issue_op, .issue_acc_write,
    .first_source_register, .second_source_register);

  // Clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  initial
  begin
    #(4 * 2000);
    n_errors++;
    conclude();
  end

  task automatic conclude();
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] ex, got);
    n_checks++;
    if (got !== ex)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Bus read, address released once taken, rready held high
  task automatic axr(input logic [31:0] ad, ex, input logic [1:0] er);
    s_axi_araddr <= ad[7:0];
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    chk("rdata", {32'h0, ex}, {32'h0, s_axi_rdata});
    chk("rresp", {62'h0, er}, {62'h0, s_axi_rresp});
  endtask

  // Bus write, address and data each released once taken
  task automatic axw(input logic [31:0] ad, d, input logic [3:0] s,
                     input logic [1:0] er);
    s_axi_awaddr <= ad[7:0];
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    chk("bresp", {62'h0, er}, {62'h0, s_axi_bresp});
  endtask

  // Reference result, accumulator and status for one op
  function automatic void predict(op_e op, logic w, logic [63:0] a, b);
    logic [31:0] p, u;
    logic [32:0] ds, da, du;
    logic [1:0]  f;
    logic [63:0] q;
    f = 2'b00;
    q = $signed(a[31:0]) * $signed(b[31:0]);
    for (int l = 0; l < 2; l++)
    begin
      p = a[32*l +: 32] * b[32*l +: 32];
      u = e_acm[32*l +: 32];
      ds = {u[31], u} - {p[31], p};
      da = {1'b0, u} + {1'b0, p};
      du = {1'b0, u} - {1'b0, p};
      e_res[32*l +: 32] = p;
      case (op)
        OP_SIGNED_SAT_ACC_NEG: {f[l], e_res[32*l +: 32]} = {ds[32] ^ ds[31],
          (ds[32] ^ ds[31]) ? (ds[32] ? SSAT_MIN : SSAT_MAX) : ds[31:0]};
        OP_USAT_ACC: {f[l], e_res[32*l +: 32]} =
          {da[32], da[32] ? USAT_MAX : da[31:0]};
        OP_USAT_ACC_NEG: {f[l], e_res[32*l +: 32]} =
          {du[32], du[32] ? USAT_MIN : du[31:0]};
        OP_UNSIGNED_ACC: e_res[32*l +: 32] = u + p;
        OP_UNSIGNED_ACC_NEG: e_res[32*l +: 32] = u - p;
        default: ;
      endcase
    end
    if (op == OP_FRAC_MUL)
      e_res = q << 1;
    if (op == OP_SIGNED_FRACTION_WORD_MAC)
      e_res = e_acm + (q << 1);
    if (op inside {OP_SIGNED_SAT_ACC_NEG, OP_USAT_ACC, OP_USAT_ACC_NEG})
      e_st = {e_st[3:2] | f, f};
    if (w || !(op inside {OP_UNSIGNED_MUL, OP_FRAC_MUL}))
      e_acm = e_res;
  endfunction

  // Issue one op, check the pulse and the state it leaves
  task automatic run(input op_e op, input logic w, input logic [63:0] a, b);
    vmac_issuer_i.issue(op, w, a, b);
    predict(op, w, a, b);
    @(negedge clk);
    chk("valid", 64'h1, {63'h0, result_valid});
    chk("ready", 64'h1, {63'h0, issue_ready});
    chk("result", e_res, result_data);
    chk("accum", e_acm, accumulator_reg);
    chk("status", {60'h0, e_st}, {60'h0, high_lane_sticky_overflow,
      low_lane_sticky_overflow, high_lane_overflow, low_lane_overflow});
    @(negedge clk);
    chk("pulse", 64'h0, {63'h0, result_valid});
    chk("hold", e_acm, accumulator_reg);
    @(posedge clk);
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_rready} = 4'h3;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    e_acm = ACC_RESET;
    e_st = STATUS_RESET;
    axr(VECTOR_STATUS_CONTROL_REG_OFFSET, 32'h0, RESP_OKAY);
    axr(ACC_HIGH_OFFSET, 32'h0, RESP_OKAY);
    axr(32'h0000_000C, 32'h0, RESP_SLVERR);
    axw(32'h0000_0040, 32'h1234_5678, 4'hF, RESP_SLVERR);
    axw(ACC_HIGH_OFFSET, 32'h8000_0000, 4'hF, RESP_OKAY);
    axw(ACC_LOW_OFFSET, 32'hAAAA_AA05, 4'h1, RESP_OKAY);
    e_acm = 64'h8000_0000_0000_0005;
    chk("accum", e_acm, accumulator_reg);
    run(OP_SIGNED_SAT_ACC_NEG, 1'b1, 64'h0000_0001_0000_0001,
        64'h0000_0001_FFFF_FFFF);
    run(OP_SIGNED_SAT_ACC_NEG, 1'b0, 64'h0000_0001_8000_0000,
        64'h0000_0001_0000_0001);
    run(OP_USAT_ACC, 1'b0, 64'hFFFF_FFFF_0000_0001,
        64'h0000_0002_0000_0001);
    run(OP_USAT_ACC_NEG, 1'b0, 64'h0000_0001_0000_0001,
        64'h0000_0001_0000_0001);
    run(OP_USAT_ACC_NEG, 1'b1, 64'hFFFF_FFFF_FFFF_FFFF,
        64'h0000_0003_0000_0003);
    run(OP_UNSIGNED_ACC, 1'b0, 64'hFFFF_FFFF_0001_0000,
        64'hFFFF_FFFF_0001_0000);
    run(OP_UNSIGNED_ACC_NEG, 1'b0, 64'h1234_5678_9ABC_DEF0,
        64'h0FED_CBA9_8765_4321);
    run(OP_UNSIGNED_MUL, 1'b0, 64'hFFFF_FFFF_FFFF_FFFE,
        64'hFFFF_FFFF_0000_0003);
    run(OP_UNSIGNED_MUL, 1'b1, 64'hFFFF_FFFF_FFFF_FFFE,
        64'hFFFF_FFFF_0000_0003);
    run(OP_FRAC_MUL, 1'b0, 64'hFFFF_0000_8000_0000,
        64'h1234_0000_8000_0000);
    run(OP_FRAC_MUL, 1'b1, 64'h0000_0000_4000_0000,
        64'h0000_0000_C000_0000);
    run(OP_SIGNED_FRACTION_WORD_MAC, 1'b0, 64'h0000_0000_7FFF_FFFF,
        64'h0000_0000_7FFF_FFFF);
    axr(VECTOR_STATUS_CONTROL_REG_OFFSET, {28'h0, e_st}, RESP_OKAY);
    axw(VECTOR_STATUS_CONTROL_REG_OFFSET, 32'h0000_000F, 4'h1, RESP_OKAY);
    e_st[3:2] = 2'b00;
    axr(VECTOR_STATUS_CONTROL_REG_OFFSET, {28'h0, e_st}, RESP_OKAY);
    axr(ACC_LOW_OFFSET, e_acm[31:0], RESP_OKAY);
    conclude();
  end
endmodule

`default_nettype wire
